// *** hdl/bioz_cfg_pkg.sv ***
// Constants, field layouts and carrier types for the bias and input mux configuration bank.
// Operation
// - Threshold field picks +-300/400/450/500 mV around mid-supply; resets to 00.
// - Bias mode 00 off; 10 biases only while channel enabled; 01/11 reserved.
// - Nonzero bias mode written without channel enable set stays 00.
// - Bias resistor code 00/01/10 gives 50/100/200 Mohm; 11 reserved; resets 01.
// - Positive bias bit ties positive sense input to mid-supply via resistor.
// - Negative bias bit ties negative sense input to mid-supply via resistor.
// - Sample rate follows master clock code and rate bit per table.
// - Calibration waveform time step derives from selected master clock.
// - Positive switch bit isolates positive sense input when 1; resets 1.
// - Negative switch bit isolates negative sense input when 1; resets 1.
// - Positive calibration select 01 ties positive input to mid-supply; resets 00.
// - Negative calibration select 01 ties negative input to mid-supply; resets 00.
// - Current generator mode field selects source type; resets 00.
// - Self-test enable bit turns modulated resistance self-test on; resets 0.
// - Self-test opens drive isolation and closes drive-to-sense switches.
// - Self-test applies bias resistors to sense inputs at 200 Mohm.
// - Channel enable bit powers channel up when 1; resets 0.
// - Master clock code selects 32768/32000/32000/31968.78 Hz from 32.768 kHz.
package bioz_cfg_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [6:0] ADDR_GENERAL   = 7'h10;
    localparam logic [6:0] ADDR_INPUT_MUX = 7'h17;

    // General configuration field positions.
    localparam int MASTER_CLOCK_LSB  = 20;
    localparam int CHANNEL_EN_BIT    = 18;
    localparam int THRESHOLD_LSB     = 6;
    localparam int RES_BIAS_LSB      = 4;
    localparam int BIAS_VALUE_LSB    = 2;
    localparam int POS_BIAS_BIT      = 1;
    localparam int NEG_BIAS_BIT      = 0;

    // Input mux configuration field positions.
    localparam int POS_ISOLATE_BIT   = 21;
    localparam int NEG_ISOLATE_BIT   = 20;
    localparam int POS_CAL_LSB       = 18;
    localparam int NEG_CAL_LSB       = 16;
    localparam int CURRENT_GEN_MODE_LSB       = 12;
    localparam int SELFTEST_BIT      = 11;

    // ********************************************************
    // Reset values and codes
    // ********************************************************
    localparam logic [1:0] THRESHOLD_RST  = 2'h0;
    localparam logic [1:0] RES_BIAS_RST   = 2'h0;
    localparam logic [1:0] BIAS_VALUE_RST = 2'h1;
    localparam logic [1:0] MASTER_CLK_RST = 2'h0;
    localparam logic [1:0] CAL_RST        = 2'h0;
    localparam logic [1:0] CURRENT_GEN_MODE_RST    = 2'h0;
    localparam logic       ISOLATE_RST    = 1'b1;
    localparam logic [1:0] RES_BIAS_ON    = 2'h2;
    localparam logic [1:0] BIAS_200M      = 2'h2;
    localparam logic [1:0] CAL_TO_MID     = 2'h1;

    // ********************************************************
    // Clock derivation: master rate as kept ticks out of a frame of input ticks
    // ********************************************************
    localparam logic [6:0] FRAME_FULL     = 7'h7f;  // 128 ticks, for codes 00 to 10
    localparam logic [6:0] FRAME_SHORT    = 7'h28;  // 41 ticks, for code 11
    localparam logic [6:0] DROP_32000     = 7'h03;  // 125 of 128 kept
    localparam logic [6:0] DROP_31968     = 7'h01;  // 40 of 41 kept
    localparam logic [10:0] SAMPLE_DIV_FAST = 11'h200;  // 512 master ticks
    localparam logic [10:0] SAMPLE_DIV_SLOW = 11'h280;  // 640 master ticks

    typedef struct packed {
        logic [1:0] leadoffThresholdSel;
        logic       resBiasActive;
        logic [1:0] biasResistorValue;
        logic       posBiasConnect;
        logic       negBiasConnect;
    } bias_ctrl_t;

    typedef struct packed {
        logic       posIsolate;
        logic       negIsolate;
        logic       posCalToMid;
        logic       negCalToMid;
        logic [1:0] currentGenMode;
        logic       selftestActive;
        logic       driveIsolOpen;
        logic       driveToSenseClose;
    } mux_ctrl_t;

endpackage

// *** hdl/master_tick_gen.sv ***
// Fractional divider that turns 32.768 kHz ticks into master clock ticks.
`timescale 1ns/1ns
module master_tick_gen
    import bioz_cfg_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       fclkTick,
    input  wire logic [1:0] masterClockSel,
    output logic            masterTick
);
    logic [6:0] frameCnt_q;
    logic       tick_q;
    wire  [6:0] frameLast = (masterClockSel == 2'h3) ? FRAME_SHORT : FRAME_FULL;
    wire  [6:0] dropCnt   = (masterClockSel == 2'h0) ? 7'h00 :
                            (masterClockSel == 2'h3) ? DROP_31968 : DROP_32000;
    wire        frameEnd  = (frameCnt_q >= frameLast);

    // Dropping the first ticks of each frame keeps the long-term rate exact.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            frameCnt_q <= 7'h00;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_q <= fclkTick && (frameCnt_q >= dropCnt);
            if (fclkTick)
                frameCnt_q <= frameEnd ? 7'h00 : frameCnt_q + 7'h01;
        end
    end

    assign masterTick = tick_q;
endmodule // master_tick_gen

// *** hdl/sample_tick_gen.sv ***
// Divider from master clock ticks down to the output sample rate.
`timescale 1ns/1ns
module sample_tick_gen
    import bioz_cfg_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       masterTick,
    input  wire logic [1:0] masterClockSel,
    input  wire logic       rateHalf,
    output logic            sampleTick
);
    logic [10:0] divCnt_q;
    logic        tick_q;
    wire  [10:0] baseDiv = masterClockSel[1] ? SAMPLE_DIV_SLOW : SAMPLE_DIV_FAST;
    wire  [10:0] divisor = rateHalf ? {baseDiv[9:0], 1'b0} : baseDiv;
    wire         divEnd  = (divCnt_q >= divisor - 11'h001);

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            divCnt_q <= 11'h000;
            tick_q   <= 1'b0;
        end
        else
        begin
            tick_q <= masterTick && divEnd;
            if (masterTick)
                divCnt_q <= divEnd ? 11'h000 : divCnt_q + 11'h001;
        end
    end

    assign sampleTick = tick_q;
endmodule // sample_tick_gen

// *** hdl/bioz_bias_mux_cfg.sv ***
// Register bank for lead bias, master clock and input mux control of the impedance channel.
`timescale 1ns/1ns
module bioz_bias_mux_cfg
    import bioz_cfg_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [6:0]  regAddr,
    input  wire logic [23:0] regWrData,
    output logic      [23:0] regRdData,
    output logic             regRdValid,
    input  wire logic        fclkTick,
    input  wire logic        rateHalf,
    output logic             channelEnable,
    output logic      [1:0]  masterClockSel,
    output logic             masterTick,
    output logic             calStepTick,
    output logic             sampleTick,
    output bias_ctrl_t       biasCtrl,
    output mux_ctrl_t        muxCtrl
);

    // ********************************************************
    // Stored fields
    // ********************************************************
    logic [1:0]  threshold_q;
    logic [1:0]  resBiasMode_q;
    logic [1:0]  biasValue_q;
    logic        posBias_q;
    logic        negBias_q;
    logic        chanEn_q;
    logic [1:0]  masterSel_q;
    logic        posIso_q;
    logic        negIso_q;
    logic [1:0]  posCal_q;
    logic [1:0]  negCal_q;
    logic [1:0]  cgMode_q;
    logic        selftest_q;
    logic [23:0] rdData_q;
    logic        rdValid_q;
    bias_ctrl_t  biasCtrl_q;
    mux_ctrl_t   muxCtrl_q;

    // ********************************************************
    // Write decode
    // ********************************************************
    wire       genWr     = regWrEn && (regAddr == ADDR_GENERAL);
    wire       muxWr     = regWrEn && (regAddr == ADDR_INPUT_MUX);
    wire [1:0] wrResBias = regWrData[RES_BIAS_LSB +: 2];
    wire       wrChanEn  = regWrData[CHANNEL_EN_BIT];

    // The channel enable may come in the same write as the bias mode.
    wire       biasAllowed = chanEn_q || wrChanEn;
    wire [1:0] resBias_d   = biasAllowed ? wrResBias : 2'h0;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            threshold_q   <= THRESHOLD_RST;
            resBiasMode_q <= RES_BIAS_RST;
            biasValue_q   <= BIAS_VALUE_RST;
            posBias_q     <= 1'b0;
            negBias_q     <= 1'b0;
            chanEn_q      <= 1'b0;
            masterSel_q   <= MASTER_CLK_RST;
        end
        else if (genWr)
        begin
            threshold_q   <= regWrData[THRESHOLD_LSB +: 2];
            resBiasMode_q <= resBias_d;
            biasValue_q   <= regWrData[BIAS_VALUE_LSB +: 2];
            posBias_q     <= regWrData[POS_BIAS_BIT];
            negBias_q     <= regWrData[NEG_BIAS_BIT];
            chanEn_q      <= wrChanEn;
            masterSel_q   <= regWrData[MASTER_CLOCK_LSB +: 2];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            posIso_q   <= ISOLATE_RST;
            negIso_q   <= ISOLATE_RST;
            posCal_q   <= CAL_RST;
            negCal_q   <= CAL_RST;
            cgMode_q   <= CURRENT_GEN_MODE_RST;
            selftest_q <= 1'b0;
        end
        else if (muxWr)
        begin
            posIso_q   <= regWrData[POS_ISOLATE_BIT];
            negIso_q   <= regWrData[NEG_ISOLATE_BIT];
            posCal_q   <= regWrData[POS_CAL_LSB +: 2];
            negCal_q   <= regWrData[NEG_CAL_LSB +: 2];
            cgMode_q   <= regWrData[CURRENT_GEN_MODE_LSB +: 2];
            selftest_q <= regWrData[SELFTEST_BIT];
        end
    end

    // ********************************************************
    // Read path
    // ********************************************************
    // Bits this block does not own read as zero.
    wire [23:0] genWord = {2'h0, masterSel_q, 1'b0, chanEn_q, 10'h000,
                           threshold_q, resBiasMode_q, biasValue_q,
                           posBias_q, negBias_q};
    wire [23:0] muxWord = {2'h0, posIso_q, negIso_q, posCal_q, negCal_q,
                           2'h0, cgMode_q, selftest_q, 11'h000};
    wire [23:0] rdSel   = (regAddr == ADDR_GENERAL)   ? genWord :
                          (regAddr == ADDR_INPUT_MUX) ? muxWord : 24'h000000;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdData_q  <= 24'h000000;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdValid_q <= regRdEn;
            if (regRdEn)
                rdData_q <= rdSel;
        end
    end

    // ********************************************************
    // Analog control decode
    // ********************************************************
    // Self-test forces the widest bias resistor on both inputs so the
    // modulated load sees a stable common mode whatever software chose.
    wire       biasActive = (resBiasMode_q == RES_BIAS_ON) && chanEn_q;
    wire [1:0] biasValEff = selftest_q ? BIAS_200M : biasValue_q;
    wire       posConnect = posBias_q || selftest_q;
    wire       negConnect = negBias_q || selftest_q;

    bias_ctrl_t biasCtrl_d;
    mux_ctrl_t  muxCtrl_d;

    always_comb
    begin
        biasCtrl_d.leadoffThresholdSel = threshold_q;
        biasCtrl_d.resBiasActive       = biasActive;
        biasCtrl_d.biasResistorValue   = biasValEff;
        biasCtrl_d.posBiasConnect      = posConnect;
        biasCtrl_d.negBiasConnect      = negConnect;
        muxCtrl_d.posIsolate           = posIso_q;
        muxCtrl_d.negIsolate           = negIso_q;
        muxCtrl_d.posCalToMid          = (posCal_q == CAL_TO_MID);
        muxCtrl_d.negCalToMid          = (negCal_q == CAL_TO_MID);
        muxCtrl_d.currentGenMode       = cgMode_q;
        muxCtrl_d.selftestActive       = selftest_q;
        muxCtrl_d.driveIsolOpen        = selftest_q;
        muxCtrl_d.driveToSenseClose    = selftest_q;
    end

    // Registered so the switch controls never glitch during a decode.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            biasCtrl_q <= '0;
            muxCtrl_q  <= '0;
        end
        else
        begin
            biasCtrl_q <= biasCtrl_d;
            muxCtrl_q  <= muxCtrl_d;
        end
    end

    // ********************************************************
    // Timing
    // ********************************************************
    logic masterTickInt;
    logic sampleTickInt;

    master_tick_gen u_master
    (
        .mclk           (mclk),
        .rst            (rst),
        .fclkTick       (fclkTick),
        .masterClockSel (masterSel_q),
        .masterTick     (masterTickInt)
    );

    sample_tick_gen u_sample
    (
        .mclk           (mclk),
        .rst            (rst),
        .masterTick     (masterTickInt),
        .masterClockSel (masterSel_q),
        .rateHalf       (rateHalf),
        .sampleTick     (sampleTickInt)
    );

    assign regRdData      = rdData_q;
    assign regRdValid     = rdValid_q;
    assign channelEnable  = chanEn_q;
    assign masterClockSel = masterSel_q;
    assign masterTick     = masterTickInt;
    assign calStepTick    = masterTickInt;
    assign sampleTick     = sampleTickInt;
    assign biasCtrl       = biasCtrl_q;
    assign muxCtrl        = muxCtrl_q;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_bias_interlock: assert property (
        genWr && (wrResBias != 2'h0) && !chanEn_q && !wrChanEn
        |=> resBiasMode_q == 2'h0)
        else $error("bias mode stored without channel enable");

    a_bias_needs_chan: assert property (
        biasCtrl.resBiasActive |-> $past(chanEn_q) && $past(resBiasMode_q == RES_BIAS_ON))
        else $error("resistive bias active without its cause");

    a_threshold_write: assert property (
        genWr |=> ##1 biasCtrl.leadoffThresholdSel == $past(regWrData[7:6], 2))
        else $error("threshold output does not follow write");

    a_selftest_drive: assert property (
        muxWr && regWrData[SELFTEST_BIT] |=> ##1
        muxCtrl.driveIsolOpen && muxCtrl.driveToSenseClose)
        else $error("self-test drive switches not set");

    a_selftest_bias: assert property (
        muxCtrl.selftestActive |-> biasCtrl.biasResistorValue == 2'h2
        && biasCtrl.posBiasConnect && biasCtrl.negBiasConnect)
        else $error("self-test bias not at widest resistor");

    a_pos_isolate: assert property (
        muxWr |=> ##1 muxCtrl.posIsolate == $past(regWrData[21], 2))
        else $error("positive isolate does not follow write");

    a_neg_isolate: assert property (
        muxWr |=> ##1 muxCtrl.negIsolate == $past(regWrData[20], 2))
        else $error("negative isolate does not follow write");

    a_cal_mid: assert property (
        muxWr && regWrData[POS_CAL_LSB +: 2] == CAL_TO_MID
        |=> ##1 muxCtrl.posCalToMid)
        else $error("positive calibration not tied to mid-supply");

    a_master_full: assert property (
        fclkTick && masterSel_q == 2'h0 && !genWr |=> masterTick)
        else $error("master tick missing at full rate");

    a_sample_on_master: assert property (
        sampleTick |-> $past(masterTick))
        else $error("sample tick not aligned to master tick");

    a_read_unmapped: assert property (
        regRdEn && regAddr != ADDR_GENERAL && regAddr != ADDR_INPUT_MUX
        |=> regRdValid && regRdData == 24'h000000)
        else $error("unmapped read not zero");

    // The bias value check skips the first edge after reset, where $past still sees
    // the cleared control registers beside the freshly reset fields.
    a_bias_value: assert property (
        !$past(rst) && !muxCtrl.selftestActive
        |-> biasCtrl.biasResistorValue == $past(biasValue_q))
        else $error("bias resistor value does not follow its field");

    a_pos_bias_on: assert property (
        genWr && regWrData[POS_BIAS_BIT] |=> ##1 biasCtrl.posBiasConnect)
        else $error("positive bias not connected after write");

    a_neg_bias_on: assert property (
        genWr && regWrData[NEG_BIAS_BIT] |=> ##1 biasCtrl.negBiasConnect)
        else $error("negative bias not connected after write");

    a_pos_bias_off: assert property (
        genWr && !regWrData[POS_BIAS_BIT] && !selftest_q
        |=> ##1 !biasCtrl.posBiasConnect)
        else $error("positive bias connected while cleared");

    a_neg_bias_off: assert property (
        genWr && !regWrData[NEG_BIAS_BIT] && !selftest_q
        |=> ##1 !biasCtrl.negBiasConnect)
        else $error("negative bias connected while cleared");

    a_neg_cal_mid: assert property (
        muxWr && regWrData[NEG_CAL_LSB +: 2] == CAL_TO_MID
        |=> ##1 muxCtrl.negCalToMid)
        else $error("negative calibration not tied to mid-supply");

    a_current_gen_mode_write: assert property (
        muxWr |=> ##1 muxCtrl.currentGenMode == $past(regWrData[CURRENT_GEN_MODE_LSB +: 2], 2))
        else $error("current generator mode does not follow write");

    a_selftest_write: assert property (
        muxWr |=> ##1 muxCtrl.selftestActive == $past(regWrData[SELFTEST_BIT], 2))
        else $error("self-test enable does not follow write");

    a_chan_enable: assert property (
        genWr |=> channelEnable == $past(regWrData[CHANNEL_EN_BIT]))
        else $error("channel enable does not follow write");

    a_master_sel: assert property (
        genWr |=> masterClockSel == $past(regWrData[MASTER_CLOCK_LSB +: 2]))
        else $error("master clock code does not follow write");

    a_master_on_fclk: assert property (
        masterTick |-> $past(fclkTick))
        else $error("master tick without input clock tick");

    a_bias_off: assert property (
        !channelEnable |=> !biasCtrl.resBiasActive)
        else $error("resistive bias active with channel off");

    a_bias_on: assert property (
        channelEnable && resBiasMode_q == RES_BIAS_ON
        |=> biasCtrl.resBiasActive)
        else $error("resistive bias not active when enabled");

    a_gen_read_zero: assert property (
        regRdEn && regAddr == ADDR_GENERAL |=> regRdData[23:22] == 2'h0
        && regRdData[19] == 1'b0 && regRdData[17:8] == 10'h000)
        else $error("unowned general bits not zero");

    a_mux_read_zero: assert property (
        regRdEn && regAddr == ADDR_INPUT_MUX |=> regRdData[23:22] == 2'h0
        && regRdData[15:14] == 2'h0 && regRdData[10:0] == 11'h000)
        else $error("unowned mux bits not zero");

    a_ignore_other: assert property (
        regWrEn && !genWr && !muxWr |=> $stable(threshold_q) && $stable(chanEn_q)
        && $stable(posIso_q) && $stable(cgMode_q))
        else $error("field changed by unmapped write");

    a_reset_defaults: assert property (
        $past(rst) |-> posIso_q && negIso_q && !chanEn_q && !selftest_q
        && biasValue_q == BIAS_VALUE_RST && threshold_q == THRESHOLD_RST)
        else $error("fields not at defaults after reset");

    c_cal_mid:     cover property (muxCtrl.posCalToMid && muxCtrl.negCalToMid);
    c_selftest_on: cover property (muxCtrl.selftestActive && muxCtrl.posIsolate);
    c_bias_active: cover property (biasCtrl.resBiasActive);
    c_sample_slow: cover property (sampleTick && masterSel_q == 2'h3 && rateHalf);
    c_interlock:   cover property (genWr && wrResBias == RES_BIAS_ON && !biasAllowed);

endmodule // bioz_bias_mux_cfg

// *** tb/bioz_bias_and_input_mux_config_test.sv ***
// Self-checking testbench for the bias, master clock and input mux configuration bank.
`timescale 1ns/1ns
module bioz_bias_and_input_mux_config_test
    import bioz_cfg_pkg::*;
;
    localparam logic [23:0] GEN_MASK = 24'h3400ff;
    localparam logic [23:0] MUX_MASK = 24'h3f3800;

    logic        mclk, rst, regWrEn, regRdEn, fclkTick, rateHalf;
    logic [6:0]  regAddr;
    logic [23:0] regWrData, regRdData, genM, muxM, expQ[$];
    logic        regRdValid, channelEnable, masterTick, calStepTick, sampleTick;
    logic [1:0]  masterClockSel;
    bias_ctrl_t  biasCtrl;
    mux_ctrl_t   muxCtrl;
    int          n_errors, checks, seed, cntM, cntC, cntS, i, r;
    logic [23:0] dR;

    bioz_bias_mux_cfg dut_u (
        .mclk(mclk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .fclkTick(fclkTick), .rateHalf(rateHalf), .channelEnable(channelEnable),
        .masterClockSel(masterClockSel), .masterTick(masterTick), .calStepTick(calStepTick),
        .sampleTick(sampleTick), .biasCtrl(biasCtrl), .muxCtrl(muxCtrl)
    );

    always #4 mclk = ~mclk;

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    begin
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    end
    endtask

    task close_out;
    begin
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    // Read results are matched against the oldest note left by the driver.
    always @(posedge mclk)
        if (!rst && regRdValid)
        begin
            if (expQ.size() == 0)
                chk("unexpected read", 24'h0, 24'hffffff);
            else
                chk("read data", expQ.pop_front(), regRdData);
        end

    always @(posedge mclk)
        if (!rst)
        begin
            cntM += masterTick;
            cntC += calStepTick;
            cntS += sampleTick;
        end

    // ************************************************************
    // Drivers
    // ************************************************************
    task doReset;
    begin
        @(negedge mclk);
        rst = 1'b1;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        genM = 24'h000004;
        muxM = 24'h300000;
        expQ.delete();
        repeat (2) @(negedge mclk);
    end
    endtask

    task wr(input logic [6:0] a, input logic [23:0] d);
        logic en;
    begin
        @(negedge mclk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge mclk);
        regWrEn = 1'b0;
        if (a == ADDR_GENERAL)
        begin
            en = genM[18] | d[18];
            genM = d & GEN_MASK;
            if (!en)
                genM[5:4] = 2'h0;
        end
        else if (a == ADDR_INPUT_MUX)
            muxM = d & MUX_MASK;
    end
    endtask

    task rd(input logic [6:0] a);
    begin
        expQ.push_back(a == ADDR_GENERAL ? genM : a == ADDR_INPUT_MUX ? muxM : 24'h0);
        @(negedge mclk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge mclk);
        regRdEn = 1'b0;
    end
    endtask

    task ctrlChk;
        logic        st;
        logic [18:0] e;
    begin
        repeat (2) @(negedge mclk);
        st = muxM[SELFTEST_BIT];
        e = {genM[18], genM[21:20], genM[7:6], genM[5:4] == RES_BIAS_ON && genM[18],
             st ? BIAS_200M : genM[3:2], genM[1] | st, genM[0] | st,
             muxM[21:20], muxM[19:18] == CAL_TO_MID, muxM[17:16] == CAL_TO_MID,
             muxM[13:12], st, st, st};
        chk("controls", {5'h0, e}, {5'h0, channelEnable, masterClockSel, biasCtrl, muxCtrl});
    end
    endtask

    task fclkPulses(input int n);
    begin
        repeat (n)
        begin
            @(negedge mclk);
            fclkTick = 1'b1;
            @(negedge mclk);
            fclkTick = 1'b0;
            @(negedge mclk);
        end
    end
    endtask

    task tickRun(input logic [1:0] code);
        int j, frame, kept, div;
    begin
        frame = (code == 2'h3) ? 41 : 128;
        kept = (code == 2'h0) ? 128 : (code == 2'h3) ? 40 : 125;
        div = (code[1] ? 640 : 512) * (code[0] ? 2 : 1);
        wr(ADDR_GENERAL, {2'h0, code, 20'h0});
        rateHalf = code[0];
        fclkPulses(frame);
        cntM = 0;
        cntC = 0;
        fclkPulses(frame * 2);
        chk("master ticks", 24'(2 * kept), cntM[23:0]);
        chk("cal step ticks", 24'(2 * kept), cntC[23:0]);
        cntS = 0;
        for (j = 0; j < 3000 && cntS == 0; j++)
            fclkPulses(1);
        limit(j);
        cntS = 0;
        cntM = 0;
        for (j = 0; j < 3000 && cntM < 2 * div; j++)
            fclkPulses(1);
        limit(j);
        // The sample tick trails its master tick by a cycle; let it land.
        repeat (2) @(negedge mclk);
        chk("sample window", 24'(2 * div), cntM[23:0]);
        chk("sample ticks", 24'h2, cntS[23:0]);
    end
    endtask

    task limit(input int j);
    begin
        if (j >= 3000)
        begin
            n_errors++;
            close_out;
        end
    end
    endtask

    task drain;
        int j;
    begin
        for (j = 0; j < 20 && expQ.size() > 0; j++)
            @(negedge mclk);
        if (expQ.size() > 0)
        begin
            n_errors++;
            close_out;
        end
    end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 7'h0;
        regWrData = 24'h0;
        fclkTick = 1'b0;
        rateHalf = 1'b0;
        seed = 74211;
        doReset;
        ctrlChk;
        rd(ADDR_GENERAL);
        rd(ADDR_INPUT_MUX);
        rd(7'h11);
        // Every threshold and bias mode code, with the channel off and then on.
        for (i = 0; i < 8; i++)
        begin
            wr(ADDR_GENERAL, {5'h0, i[2], 10'h0, i[1:0], i[1:0], i[1:0], i[0], i[1]});
            rd(ADDR_GENERAL);
            ctrlChk;
        end
        wr(ADDR_GENERAL, 24'h040020);
        ctrlChk;
        wr(ADDR_GENERAL, 24'h000020);
        rd(ADDR_GENERAL);
        ctrlChk;
        wr(ADDR_GENERAL, 24'h000020);
        rd(ADDR_GENERAL);
        wr(ADDR_INPUT_MUX, 24'h300800);
        ctrlChk;
        rd(ADDR_INPUT_MUX);
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_INPUT_MUX, {2'h0, i[1], i[0], i[1:0], i[1:0], 2'h0, i[1:0], 12'h0});
            rd(ADDR_INPUT_MUX);
            ctrlChk;
        end
        // Random words, including unmapped neighbours that must stay inert.
        for (i = 0; i < 40; i++)
        begin
            r = $random(seed);
            dR = 24'($random(seed));
            dR[21:20] = dR[21:20] | {2{dR[11]}};
            wr(r[1] ? (r[0] ? ADDR_GENERAL : ADDR_INPUT_MUX) : (r[0] ? 7'h0f : 7'h18), dR);
            rd(ADDR_GENERAL);
            rd(ADDR_INPUT_MUX);
            ctrlChk;
        end
        drain;
        for (i = 0; i < 4; i++)
            tickRun(i[1:0]);
        // A reset in mid-run must bring every field back to its default.
        wr(ADDR_GENERAL, 24'h3400ff);
        wr(ADDR_INPUT_MUX, 24'h0f3800);
        doReset;
        ctrlChk;
        rd(ADDR_GENERAL);
        rd(ADDR_INPUT_MUX);
        drain;
        close_out;
    end

    initial
    begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        close_out;
    end

endmodule // bioz_bias_and_input_mux_config_test
